// ==== design/serep_core.sv ====
// Status byte, event flags, masks, service request and wait handling
//
// Functional notes
// (R01) Wait command stalls all later commands until pending operations end.
// (R02) Four 8-bit status and enable registers plus output and error queues.
// (R03) Register queries return the binary weight sum of set bits.
// (R04) Status bit 2 shows the error queue holds an unread entry.
// (R05) Status bit 4 shows the output queue holds a response.
// (R06) Status bit 5 is the event summary of latched event flags.
// (R07) Bit 6 is request-service on serial poll, master summary on query.
// (R08) Master summary comes only from status bits 5, 4 and 2.
// (R09) Service request mask is written and read back by command.
// (R10) Mask bit 2 raises service request when an error entry is queued.
// (R11) Mask bit 4 raises service request when a response is queued.
// (R12) Mask bit 5 raises service request when event summary sets.
// (R13) Reading the event flags returns them, then clears them all.
// (R14) Event bit 0 sets when pending operations finish after complete command.
// (R15) Event bit 2 sets when output queue data is lost.
// (R16) Event bit 4 sets on a fault while executing.
// (R17) Event bit 5 sets on a fault while parsing.
// (R18) Event bit 7 is set at power-on.
// (R19) Event summary sets when an enabled event flag is set.
// (R20) Enabled status bit sets master summary and raises service request.
// (R21) Request-service reads clear after one serial poll reports it.
// (R22) Error queue holds ten entries in order, reading removes one.
// (R23) Unused bits read zero; writes to unused mask bits ignored.
`timescale 1ns/1ps
`default_nettype none
module serep_core (
    // System
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    // Command port
    input  wire logic                       cmd_valid,
    input  wire serep_pkg::serep_cmd_t      cmd_code,
    input  wire logic [7:0]                 cmd_data,
    output logic                            cmd_ready,
    // Query response
    output logic                            resp_valid,
    output logic      [7:0]                 resp_data,
    // Serial poll
    input  wire logic                       spoll_req,
    output logic                            spoll_valid,
    output logic      [7:0]                 spoll_data,
    // Instrument events
    input  wire logic                       ops_pending,
    input  wire logic                       outq_put,
    input  wire logic                       outq_avail,
    input  wire logic                       outq_lost,
    input  wire logic                       exec_err,
    input  wire logic                       cmd_err,
    input  wire logic                       err_push,
    input  wire logic [7:0]                 err_code,
    // Service request
    output logic                            srq
);

    serep_pkg::serep_state_t st_q;
    serep_pkg::serep_state_t st_d;

    logic [7:0] sre_q;
    logic [7:0] sre_d;
    logic [7:0] ese_q;
    logic [7:0] ese_d;
    logic [7:0] esr_q;
    logic [7:0] esr_d;
    logic       opc_armed_q;
    logic       opc_armed_d;
    logic       rqs_q;
    logic       rqs_d;
    logic       mss_prev_q;
    logic       esb_prev_q;
    logic       resp_valid_q;
    logic       resp_valid_d;
    logic [7:0] resp_data_q;
    logic [7:0] resp_data_d;
    logic       spoll_valid_q;
    logic [7:0] spoll_data_q;
    logic [7:0] spoll_data_d;

    logic       take;
    logic       errq_pop;
    logic       errq_empty;
    logic       errq_full;
    logic [7:0] errq_data;
    logic       errq_added;
    logic [7:0] stb_w;
    logic       mss_w;
    logic [7:0] esr_set;
    logic       esr_clr;
    logic       rqs_set;

    assign take      = cmd_valid && cmd_ready;
    assign cmd_ready = (st_q == serep_pkg::ST_IDLE); // R01
    assign errq_pop  = take && (cmd_code == serep_pkg::CMD_ERR_Q);
    // A full queue still takes an entry when a read frees a slot
    assign errq_added = err_push && (!errq_full || errq_pop);

    serep_err_fifo u_errq (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .push      (err_push),
        .push_data (err_code),
        .pop       (errq_pop),
        .rd_data_q (errq_data),
        .empty     (errq_empty),
        .full      (errq_full)
    ); // R22

    // Status byte as seen without bit 6
    always_comb begin
        stb_w = serep_pkg::ZERO_BYTE;
        stb_w[serep_pkg::STB_ERRQ_BIT] = !errq_empty; // R04
        stb_w[serep_pkg::STB_MAV_BIT]  = outq_avail; // R05
        stb_w[serep_pkg::STB_ESB_BIT]  = |(esr_q & ese_q); // R06 R19
    end

    // Mask holds only bits 2, 4 and 5, so only those feed the summary
    assign mss_w = |(stb_w & sre_q); // R08 R20

    // Event flag sources
    always_comb begin
        esr_set = serep_pkg::ZERO_BYTE;
        esr_set[serep_pkg::ESR_OPC_BIT] = opc_armed_q && !ops_pending; // R14
        esr_set[serep_pkg::ESR_QYE_BIT] = outq_lost; // R15
        esr_set[serep_pkg::ESR_EXE_BIT] = exec_err; // R16
        esr_set[serep_pkg::ESR_CME_BIT] = cmd_err; // R17
    end

    assign esr_clr = take && (cmd_code == serep_pkg::CMD_ESR_Q);

    // Service request raise sources
    assign rqs_set = (mss_w && !mss_prev_q)                      // R12 R20
                  || (stb_w[serep_pkg::STB_ESB_BIT] && !esb_prev_q
                      && sre_q[serep_pkg::STB_ESB_BIT])           // R12
                  || (errq_added && sre_q[serep_pkg::STB_ERRQ_BIT]) // R10
                  || (outq_put && sre_q[serep_pkg::STB_MAV_BIT]); // R11

    // Command sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            serep_pkg::ST_IDLE: begin
                if (take && cmd_code == serep_pkg::CMD_WAI && ops_pending) begin
                    st_d = serep_pkg::ST_WAIT; // R01
                end else if (errq_pop) begin
                    st_d = serep_pkg::ST_ERRRD;
                end
            end
            serep_pkg::ST_WAIT: begin
                if (!ops_pending) begin
                    st_d = serep_pkg::ST_IDLE; // R01
                end
            end
            serep_pkg::ST_ERRRD: begin
                st_d = serep_pkg::ST_IDLE;
            end
            default: begin
                st_d = serep_pkg::ST_IDLE;
            end
        endcase
    end

    // Registers, flags and responses
    always_comb begin
        sre_d        = sre_q;
        ese_d        = ese_q;
        opc_armed_d  = opc_armed_q;
        resp_valid_d = 1'b0;
        resp_data_d  = resp_data_q;
        spoll_data_d = spoll_data_q;
        // Set wins over the read clear
        esr_d = (esr_clr ? serep_pkg::ZERO_BYTE : esr_q) | esr_set; // R13
        if (esr_set[serep_pkg::ESR_OPC_BIT]) begin
            opc_armed_d = 1'b0;
        end
        if (st_q == serep_pkg::ST_ERRRD) begin
            resp_valid_d = 1'b1;
            resp_data_d  = errq_data; // R22
        end
        if (take) begin
            case (cmd_code)
                serep_pkg::CMD_STB_Q: begin
                    resp_valid_d = 1'b1;
                    resp_data_d  = stb_w; // R03
                    resp_data_d[serep_pkg::STB_MSS_BIT] = mss_w; // R07
                end
                serep_pkg::CMD_SRE_W: begin
                    sre_d = cmd_data & serep_pkg::SRE_VALID; // R09 R23
                end
                serep_pkg::CMD_SRE_Q: begin
                    resp_valid_d = 1'b1;
                    resp_data_d  = sre_q; // R09
                end
                serep_pkg::CMD_ESR_Q: begin
                    resp_valid_d = 1'b1;
                    resp_data_d  = esr_q; // R13
                end
                serep_pkg::CMD_ESE_W: begin
                    ese_d = cmd_data & serep_pkg::ESE_VALID; // R23
                end
                serep_pkg::CMD_ESE_Q: begin
                    resp_valid_d = 1'b1;
                    resp_data_d  = ese_q; // R02
                end
                serep_pkg::CMD_OPC: begin
                    opc_armed_d = 1'b1; // R14
                end
                default: begin
                end
            endcase
        end
        if (spoll_req) begin
            spoll_data_d = stb_w;
            spoll_data_d[serep_pkg::STB_MSS_BIT] = rqs_q; // R07
        end
        // A raise in the polling cycle is kept for the next poll
        rqs_d = (rqs_q && !spoll_req) || rqs_set; // R21
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            st_q          <= serep_pkg::ST_IDLE;
            sre_q         <= serep_pkg::SRE_RESET;
            ese_q         <= serep_pkg::ESE_RESET;
            esr_q         <= serep_pkg::ESR_RESET; // R18
            opc_armed_q   <= 1'b0;
            rqs_q         <= 1'b0;
            mss_prev_q    <= 1'b0;
            esb_prev_q    <= 1'b0;
            resp_valid_q  <= 1'b0;
            resp_data_q   <= serep_pkg::ZERO_BYTE;
            spoll_valid_q <= 1'b0;
            spoll_data_q  <= serep_pkg::ZERO_BYTE;
        end else begin
            st_q          <= st_d;
            sre_q         <= sre_d;
            ese_q         <= ese_d;
            esr_q         <= esr_d;
            opc_armed_q   <= opc_armed_d;
            rqs_q         <= rqs_d;
            mss_prev_q    <= mss_w;
            esb_prev_q    <= stb_w[serep_pkg::STB_ESB_BIT];
            resp_valid_q  <= resp_valid_d;
            resp_data_q   <= resp_data_d;
            spoll_valid_q <= spoll_req;
            spoll_data_q  <= spoll_data_d;
        end
    end

    assign resp_valid  = resp_valid_q;
    assign resp_data   = resp_data_q;
    assign spoll_valid = spoll_valid_q;
    assign spoll_data  = spoll_data_q;
    assign srq         = rqs_q; // R20

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_wai_holds_cmds: assert property ( // R01
        take && cmd_code == serep_pkg::CMD_WAI && ops_pending
        |=> !cmd_ready ##0 (st_q == serep_pkg::ST_WAIT))
        else $error("wait command did not stall the command port");

    a_wai_keeps_stall: assert property ( // R01
        st_q == serep_pkg::ST_WAIT && ops_pending |=> !cmd_ready)
        else $error("command port opened while operations pending");

    a_wai_releases: assert property ( // R01
        st_q == serep_pkg::ST_WAIT && !ops_pending |=> cmd_ready)
        else $error("command port stayed stalled after operations ended");

    a_errq_resp_timing: assert property ( // R22
        errq_pop |=> !cmd_ready ##1 resp_valid)
        else $error("error queue read answer out of time");

    a_esr_read_clear: assert property ( // R13
        esr_clr |=> esr_q == $past(esr_set))
        else $error("event flags not cleared by their read");

    a_esr_resp_value: assert property ( // R03
        esr_clr |=> resp_valid && resp_data == $past(esr_q))
        else $error("event flag read returned the wrong value");

    a_pon_after_reset: assert property ( // R18
        $fell(reset) |-> esr_q[serep_pkg::ESR_PON_BIT])
        else $error("power-on flag missing after reset");

    a_errq_bit_sets: assert property ( // R04
        spoll_req |=> spoll_data[serep_pkg::STB_ERRQ_BIT]
            != $past(errq_empty))
        else $error("queue-not-empty bit wrong on serial poll");

    a_mav_follows: assert property ( // R05
        spoll_req |=> spoll_valid
            && spoll_data[serep_pkg::STB_MAV_BIT] == $past(outq_avail))
        else $error("message available bit wrong on serial poll");

    a_mss_sources: assert property ( // R08
        mss_w |-> (stb_w[2] && sre_q[2]) || (stb_w[4] && sre_q[4])
               || (stb_w[5] && sre_q[5]))
        else $error("master summary set without an enabled source");

    // Master summary rebuilt from its sources for the query check
    logic mss_ref;
    assign mss_ref = (outq_avail && sre_q[4]) || (!errq_empty && sre_q[2])
                  || ((|(esr_q & ese_q)) && sre_q[5]);

    a_stb_query_mss: assert property ( // R07
        take && cmd_code == serep_pkg::CMD_STB_Q |=> resp_valid
            && resp_data[serep_pkg::STB_MSS_BIT] == $past(mss_ref))
        else $error("status query master summary bit wrong");

    a_spoll_rqs: assert property ( // R07
        spoll_req |=> spoll_data[serep_pkg::STB_MSS_BIT] == $past(srq))
        else $error("serial poll request-service bit wrong");

    a_srq_holds: assert property ( // R20
        srq && !spoll_req |=> srq)
        else $error("service request dropped without a serial poll");

    a_esb_raises_srq: assert property ( // R12
        sre_q[serep_pkg::STB_ESB_BIT] && !spoll_req
        && $rose(stb_w[serep_pkg::STB_ESB_BIT]) |=> srq)
        else $error("event summary did not raise a service request");

    a_errq_raises_srq: assert property ( // R10
        errq_added && sre_q[serep_pkg::STB_ERRQ_BIT] |=> srq)
        else $error("error entry did not raise a service request");

    a_mav_raises_srq: assert property ( // R11
        outq_put && sre_q[serep_pkg::STB_MAV_BIT] |=> srq)
        else $error("output response did not raise a service request");

    a_rqs_reported_once: assert property ( // R21
        spoll_req && rqs_q && !rqs_set |=> !rqs_q ##0 spoll_data[6])
        else $error("request-service not cleared after serial poll");

    a_opc_sets_flag: assert property ( // R14
        opc_armed_q && !ops_pending |=> esr_q[serep_pkg::ESR_OPC_BIT]
            ##0 !opc_armed_q)
        else $error("operation complete flag not set");

    a_err_flags_set: assert property ( // R16
        exec_err || cmd_err || outq_lost
        |=> (esr_q[4] || !$past(exec_err)) && (esr_q[5] || !$past(cmd_err))
            && (esr_q[2] || !$past(outq_lost)))
        else $error("error event did not latch its flag");

    a_sre_unused_zero: assert property ( // R23
        (sre_q & ~serep_pkg::SRE_VALID) == 8'h00
        && (ese_q & ~serep_pkg::ESE_VALID) == 8'h00)
        else $error("unused mask bit holds a one");

endmodule // serep_core
`default_nettype wire

// ==== design/serep_pkg.sv ====
// Shared constants and types of the status and event reporting block
package serep_pkg;

    // Register width and error queue geometry
    localparam int unsigned REG_W      = 8;
    localparam int unsigned ERRQ_DEPTH = 10;
    localparam int unsigned ERRQ_AW    = 4;

    // Summary status byte bit positions
    localparam int unsigned STB_ERRQ_BIT = 2;
    localparam int unsigned STB_MAV_BIT  = 4;
    localparam int unsigned STB_ESB_BIT  = 5;
    localparam int unsigned STB_MSS_BIT  = 6;

    // Latched event flag bit positions
    localparam int unsigned ESR_OPC_BIT = 0;
    localparam int unsigned ESR_QYE_BIT = 2;
    localparam int unsigned ESR_EXE_BIT = 4;
    localparam int unsigned ESR_CME_BIT = 5;
    localparam int unsigned ESR_PON_BIT = 7;

    // Writable bits of the masks, all others read as zero
    localparam logic [7:0] SRE_VALID = 8'h34;
    localparam logic [7:0] ESE_VALID = 8'hb5;

    // Reset values
    localparam logic [7:0] SRE_RESET = 8'h00;
    localparam logic [7:0] ESE_RESET = 8'h00;
    localparam logic [7:0] ESR_RESET = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // Common commands and queries accepted on the command port
    typedef enum logic [3:0] {
        CMD_NONE  = 4'h0,
        CMD_STB_Q = 4'h1,
        CMD_SRE_W = 4'h2,
        CMD_SRE_Q = 4'h3,
        CMD_ESR_Q = 4'h4,
        CMD_ESE_W = 4'h5,
        CMD_ESE_Q = 4'h6,
        CMD_OPC   = 4'h7,
        CMD_WAI   = 4'h8,
        CMD_ERR_Q = 4'h9
    } serep_cmd_t;

    // Command sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_ERRRD = 2'b10
    } serep_state_t;

endpackage

// ==== design/serep_err_fifo.sv ====
// Error and event queue: ten entries, first in first out
`timescale 1ns/1ps
`default_nettype none
module serep_err_fifo (
    // System
    input  wire logic                           clk_sys,
    input  wire logic                           reset,
    // Write side
    input  wire logic                           push,
    input  wire logic [serep_pkg::REG_W-1:0]    push_data,
    // Read side
    input  wire logic                           pop,
    output logic      [serep_pkg::REG_W-1:0]    rd_data_q,
    // Status
    output logic                                empty,
    output logic                                full
);

    logic [serep_pkg::REG_W-1:0]   mem_q [serep_pkg::ERRQ_DEPTH];
    logic [serep_pkg::ERRQ_AW-1:0] wr_ptr_q;
    logic [serep_pkg::ERRQ_AW-1:0] wr_ptr_d;
    logic [serep_pkg::ERRQ_AW-1:0] rd_ptr_q;
    logic [serep_pkg::ERRQ_AW-1:0] rd_ptr_d;
    logic [serep_pkg::ERRQ_AW-1:0] cnt_q;
    logic [serep_pkg::ERRQ_AW-1:0] cnt_d;
    logic [serep_pkg::REG_W-1:0]   rd_data_d;
    logic                          do_push;
    logic                          do_pop;

    localparam logic [serep_pkg::ERRQ_AW-1:0] LAST =
        4'(serep_pkg::ERRQ_DEPTH - 1);
    localparam logic [serep_pkg::ERRQ_AW-1:0] DEPTH =
        4'(serep_pkg::ERRQ_DEPTH);

    assign empty   = (cnt_q == 4'h0);
    assign full    = (cnt_q == DEPTH);
    assign do_pop  = pop && !empty;
    // A push into a full queue is dropped unless a pop frees a slot in the same cycle
    assign do_push = push && (!full || do_pop);

    always_comb begin
        wr_ptr_d  = wr_ptr_q;
        rd_ptr_d  = rd_ptr_q;
        cnt_d     = cnt_q;
        rd_data_d = rd_data_q;
        if (do_push) begin
            wr_ptr_d = (wr_ptr_q == LAST) ? 4'h0 : wr_ptr_q + 4'h1;
        end
        if (pop) begin
            // Reading an empty queue returns zero, meaning no error
            rd_data_d = do_pop ? mem_q[rd_ptr_q] : serep_pkg::ZERO_BYTE;
        end
        if (do_pop) begin
            rd_ptr_d = (rd_ptr_q == LAST) ? 4'h0 : rd_ptr_q + 4'h1;
        end
        if (do_push && !do_pop) begin
            cnt_d = cnt_q + 4'h1;
        end else if (do_pop && !do_push) begin
            cnt_d = cnt_q - 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wr_ptr_q  <= 4'h0;
            rd_ptr_q  <= 4'h0;
            cnt_q     <= 4'h0;
            rd_data_q <= serep_pkg::ZERO_BYTE;
        end else begin
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
            cnt_q     <= cnt_d;
            rd_data_q <= rd_data_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (do_push) begin
            mem_q[wr_ptr_q] <= push_data;
        end
    end

endmodule // serep_err_fifo
`default_nettype wire

// ==== dv/serep_ctrl_model.sv ====
// Bus controller model that issues common commands and serial polls
`timescale 1ns/1ps
`default_nettype none
module serep_ctrl_model (
    // System
    input  wire logic                  clk_sys,
    // Command port
    output var  logic                  cmd_valid,
    output var  serep_pkg::serep_cmd_t cmd_code,
    output var  logic [7:0]            cmd_data,
    input  wire logic                  cmd_ready,
    // Query response
    input  wire logic                  resp_valid,
    input  wire logic [7:0]            resp_data,
    // Serial poll
    output var  logic                  spoll_req,
    input  wire logic                  spoll_valid,
    input  wire logic [7:0]            spoll_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = serep_pkg::CMD_NONE;
        cmd_data  = 8'h00;
        spoll_req = 1'b0;
    end

    // Holds the command until a falling edge sees ready, giving up after 64 edges, then inverts the data
    task automatic send(input serep_pkg::serep_cmd_t c,
                        input logic [7:0] d, output bit ok);
        ok = 1'b0;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_code  = c;
        cmd_data  = d;
        for (int n = 0; n < 64 && !ok; n++) begin
            if (cmd_ready === 1'b1)
                ok = 1'b1;
            @(negedge clk_sys);
        end
        cmd_valid = 1'b0;
        cmd_code  = serep_pkg::CMD_NONE;
        cmd_data  = ~d;
    endtask

    task automatic query(input serep_pkg::serep_cmd_t c,
                         output logic [7:0] v, output bit ok);
        bit got;
        got = 1'b0;
        v   = 8'h00;
        send(c, 8'h00, ok);
        for (int n = 0; n < 4 && !got; n++) begin
            if (resp_valid === 1'b1) begin
                got = 1'b1;
                v   = resp_data;
            end
            else
                @(negedge clk_sys);
        end
        ok = ok && got;
    endtask

    task automatic poll(output logic [7:0] v, output bit ok);
        @(negedge clk_sys);
        spoll_req = 1'b1;
        @(negedge clk_sys);
        spoll_req = 1'b0;
        ok = (spoll_valid === 1'b1);
        v  = spoll_data;
    endtask
endmodule // serep_ctrl_model
`default_nettype wire

// ==== dv/status_event_reporting_tb.sv ====
// Self-checking testbench of the status and event reporting block
`timescale 1ns/1ps
`default_nettype none
module status_event_reporting_tb;
    logic                  clk_sys = 1'b0;
    logic                  reset = 1'b1;
    logic                  cmd_valid;
    serep_pkg::serep_cmd_t cmd_code;
    logic [7:0]            cmd_data;
    logic                  cmd_ready;
    logic                  resp_valid;
    logic [7:0]            resp_data;
    logic                  spoll_req;
    logic                  spoll_valid;
    logic [7:0]            spoll_data;
    logic                  ops_pending = 1'b0;
    logic                  outq_avail = 1'b0;
    logic [4:0]            ev = 5'h00;
    logic [7:0]            err_code = 8'h00;
    logic                  srq;
    int                    mismatches = 0;
    int                    check_count = 0;

    always #25 clk_sys = ~clk_sys;

    serep_core uut (
        .clk_sys(clk_sys), .reset(reset),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .spoll_req(spoll_req),
        .spoll_valid(spoll_valid), .spoll_data(spoll_data),
        .ops_pending(ops_pending), .outq_put(ev[0]),
        .outq_avail(outq_avail), .outq_lost(ev[1]), .exec_err(ev[2]),
        .cmd_err(ev[3]), .err_push(ev[4]), .err_code(err_code), .srq(srq)
    );

    serep_ctrl_model ctrl (
        .clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .cmd_data(cmd_data), .cmd_ready(cmd_ready),
        .resp_valid(resp_valid), .resp_data(resp_data),
        .spoll_req(spoll_req), .spoll_valid(spoll_valid),
        .spoll_data(spoll_data)
    );

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic hang();
        mismatches++;
        $display("[FAIL] handshake expected 01 seen 00");
        report_and_stop();
    endtask

    task automatic cmd(input serep_pkg::serep_cmd_t c, input logic [7:0] d);
        bit ok;
        ctrl.send(c, d, ok);
        if (!ok)
            hang();
    endtask

    task automatic qry(input string nm, input serep_pkg::serep_cmd_t c,
                       input logic [7:0] exp);
        bit         ok;
        logic [7:0] v;
        ctrl.query(c, v, ok);
        if (!ok)
            hang();
        check(nm, v, exp);
    endtask

    task automatic poll(input logic [7:0] exp);
        bit         ok;
        logic [7:0] v;
        ctrl.poll(v, ok);
        if (!ok)
            hang();
        check("spoll_data", v, exp);
    endtask

    // One-cycle event strobe, with a gap cycle before it
    task automatic pulse(input int k, input logic [7:0] d);
        @(negedge clk_sys);
        err_code = d;
        ev[k] = 1'b1;
        @(negedge clk_sys);
        ev[k] = 1'b0;
    endtask

    task automatic end_test(input string nm);
        $display("Test %s finished", nm);
    endtask

    initial begin
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        qry("stb", serep_pkg::CMD_STB_Q, 8'h00);
        qry("esr", serep_pkg::CMD_ESR_Q, 8'h80);
        qry("esr", serep_pkg::CMD_ESR_Q, 8'h00);
        end_test("power_on");
        cmd(serep_pkg::CMD_SRE_W, 8'hff);
        qry("sre", serep_pkg::CMD_SRE_Q, 8'h34);
        cmd(serep_pkg::CMD_ESE_W, 8'hff);
        qry("ese", serep_pkg::CMD_ESE_Q, 8'hb5);
        end_test("masks");
        cmd(serep_pkg::CMD_SRE_W, 8'h20);
        pulse(2, 8'h00);
        repeat (3) @(negedge clk_sys);
        check("srq", {7'h00, srq}, 8'h01);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h60);
        poll(8'h60);
        poll(8'h20);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h60);
        pulse(1, 8'h00);
        pulse(3, 8'h00);
        qry("esr", serep_pkg::CMD_ESR_Q, 8'h34);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h00);
        end_test("events");
        cmd(serep_pkg::CMD_SRE_W, 8'h04);
        for (int i = 0; i < 11; i++)
            pulse(4, 8'h40 + 8'(i));
        check("srq", {7'h00, srq}, 8'h01);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h44);
        poll(8'h44);
        for (int i = 0; i < 10; i++)
            qry("err", serep_pkg::CMD_ERR_Q, 8'h40 + 8'(i));
        qry("err", serep_pkg::CMD_ERR_Q, 8'h00);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h00);
        end_test("error_queue");
        cmd(serep_pkg::CMD_SRE_W, 8'h10);
        outq_avail = 1'b1;
        @(negedge clk_sys);
        poll(8'h50);
        pulse(0, 8'h00);
        @(negedge clk_sys);
        check("srq", {7'h00, srq}, 8'h01);
        qry("stb", serep_pkg::CMD_STB_Q, 8'h50);
        poll(8'h50);
        outq_avail = 1'b0;
        qry("stb", serep_pkg::CMD_STB_Q, 8'h00);
        end_test("output_queue");
        ops_pending = 1'b1;
        cmd(serep_pkg::CMD_OPC, 8'h00);
        cmd(serep_pkg::CMD_WAI, 8'h00);
        for (int i = 0; i < 4; i++) begin
            check("cmd_ready", {7'h00, cmd_ready}, 8'h00);
            @(negedge clk_sys);
        end
        ops_pending = 1'b0;
        qry("esr", serep_pkg::CMD_ESR_Q, 8'h01);
        end_test("wait_and_complete");
        reset = 1'b1;
        repeat (5) @(negedge clk_sys);
        reset = 1'b0;
        check("srq", {7'h00, srq}, 8'h00);
        qry("esr", serep_pkg::CMD_ESR_Q, 8'h80);
        end_test("reset_again");
        report_and_stop();
    end
endmodule // status_event_reporting_tb
`default_nettype wire
